// ==== inc/uss_pkg.sv ====
package uss_pkg;
   // register byte offsets on the APB window
   localparam logic [7:0] USS_OFS_RCSTA = 8'h00;
   localparam logic [7:0] USS_OFS_TXSTA = 8'h04;
   localparam logic [7:0] USS_OFS_BAUD = 8'h08;
   localparam logic [7:0] USS_OFS_RXDATA = 8'h0C;
   localparam logic [7:0] USS_OFS_TXDATA = 8'h10;
   localparam logic [7:0] USS_OFS_IRQEN = 8'h14;
   localparam logic [7:0] USS_OFS_IRQFLG = 8'h18;
   localparam logic [7:0] USS_OFS_IRQPRI = 8'h1C;
   localparam logic [7:0] USS_OFS_CORE = 8'h20;
   // bit positions inside the irq, baud and core registers
   localparam int USS_BIT_RCIF = 5;
   localparam int USS_BIT_TXIF = 4;
   localparam int USS_BIT_RCIDL = 6;
   localparam int USS_BIT_CLOCK_POLARITY_SELECT = 4;
   localparam int USS_BIT_GIE = 7;
   localparam int USS_BIT_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int USS_BIT_SLEEP = 0;
   // reset value and baud write mask
   localparam logic [7:0] USS_RST_REG = 8'h00;
   localparam logic [7:0] USS_BAUD_WMASK = 8'h1B;
   // core resumes here when the interrupt routine is called
   localparam logic [11:0] USS_ISR_VECTOR = 12'h004;
   localparam int USS_RX_FIFO_DEPTH = 2;
   localparam logic [3:0] USS_LEN8 = 4'h7;
   localparam logic [3:0] USS_LEN9 = 4'h8;

   typedef struct packed {
      logic serial_port_enable;
      logic rx9;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic adden;
      logic framing_error_flag;
      logic overrun_error_flag;
      logic received_ninth_bit;
   } uss_rcsta_t;

   typedef struct packed {
      logic clock_source_select;
      logic tx9;
      logic transmit_enable;
      logic sync;
      logic sendb;
      logic brgh;
      logic trmt;
      logic transmit_ninth_bit;
   } uss_txsta_t;
endpackage

// ==== hw/uss_top.sv ====
`timescale 1ns/10ps
module uss_top
   import uss_pkg::*;
#(
   parameter int RX_DEPTH = USS_RX_FIFO_DEPTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic shift_clock_pin,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   output logic irq_req,
   output logic wake,
   output logic isr_call,
   output logic [11:0] isr_addr
);
   localparam int PW = $clog2(RX_DEPTH) > 0 ? $clog2(RX_DEPTH) : 1;

   initial begin
      if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
         $error("RX_DEPTH must be a power of two, at least 2");
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   uss_rcsta_t rcsta_q;
   uss_txsta_t txsta_q;
   logic [7:0] baud_q, ie_q, ipr_q, core_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
   logic [8:0] rsr_q;
   logic [3:0] rx_cnt_q;
   logic [8:0] fifo_q [RX_DEPTH];
   logic [PW-1:0] wp_q, rp_q;
   logic [PW:0] fcnt_q;
   logic overrun_error_flag_q;
   logic [8:0] tsr_q, txb_q;
   logic [3:0] tx_cnt_q;
   logic busy_q, txb_v_q, dout_q;
   logic rcif_p_q, txif_p_q;
   logic irq_q, wake_q, call_q;
   // pin enable and vector are flops so that every output is registered
   logic tx_en_q;
   logic [11:0] isr_addr_q;

   // decoded bus strobes: a transfer completes when the slave has raised pready
   logic xfer, wr, rd, mapped;
   assign xfer = psel & penable & pready_q;
   // a refused offset must neither write a register nor pop the fifo
   assign wr = xfer & pwrite & mapped;
   assign rd = xfer & ~pwrite & mapped;
   assign mapped = paddr <= USS_OFS_CORE && paddr[1:0] == 2'b00;

   // mode decode
   logic slave_mode, rx_en, tx_en, clock_polarity_select, rise, fall, smp_edge, drv_edge;
   assign slave_mode = rcsta_q.serial_port_enable & txsta_q.sync & ~txsta_q.clock_source_select;
   // single-receive enable is not looked at in slave mode
   assign rx_en = slave_mode & rcsta_q.continuous_receive_enable;
   assign tx_en = slave_mode & txsta_q.transmit_enable & ~rcsta_q.continuous_receive_enable;
   assign clock_polarity_select = baud_q[USS_BIT_CLOCK_POLARITY_SELECT];
   assign rise = ck_s2_q & ~ck_s3_q;
   assign fall = ~ck_s2_q & ck_s3_q;
   // data is taken on one edge and launched on the other
   assign smp_edge = clock_polarity_select ? fall : rise;
   assign drv_edge = clock_polarity_select ? rise : fall;

   // pins cross into pclk through two flops before any edge logic looks at them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dt_s1_q <= 1'b0;
         dt_s2_q <= 1'b0;
      end else begin
         ck_s1_q <= shift_clock_pin;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= serial_data_pin_in;
         dt_s2_q <= dt_s1_q;
      end
   end

   // receive fifo status
   logic rx_empty, rx_full, rx_pop, rx_done, rx_push, rx_ovf, rcif, txif;
   logic [3:0] rx_last;
   assign rx_empty = (fcnt_q == '0);
   assign rx_full = (fcnt_q == (PW+1)'(RX_DEPTH));
   assign rx_last = rcsta_q.rx9 ? USS_LEN9 : USS_LEN8;
   // only the external clock edge advances the shifter; with no slave mode nothing moves,
   // which is also what keeps the unit quiet in sleep outside slave mode
   assign rx_done = rx_en & smp_edge & (rx_cnt_q == rx_last);
   assign rx_push = rx_done & ~rx_full;
   assign rx_ovf = rx_done & rx_full;
   assign rx_pop = rd & hit(paddr, USS_OFS_RXDATA) & ~rx_empty;
   assign rcif = ~rx_empty;
   assign txif = ~txb_v_q;

   // receive shifter: lsb first, bit index counts the position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsr_q <= 9'h000;
         rx_cnt_q <= 4'h0;
      end else if (!rx_en) begin
         rx_cnt_q <= 4'h0;
      end else if (smp_edge) begin
         rsr_q[rx_cnt_q] <= dt_s2_q;
         rx_cnt_q <= (rx_cnt_q == rx_last) ? 4'h0 : rx_cnt_q + 4'h1;
      end
   end

   // word assembled from the shifter plus the bit arriving now
   logic [8:0] rx_word;
   always_comb begin
      rx_word = rsr_q;
      rx_word[rx_last] = dt_s2_q;
      if (!rcsta_q.rx9) begin
         rx_word[8] = 1'b0;
      end
   end

   // receive fifo; clearing port enable flushes it with the rest of the unit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q <= '0;
         rp_q <= '0;
         fcnt_q <= '0;
      end else if (!rcsta_q.serial_port_enable) begin
         wp_q <= '0;
         rp_q <= '0;
         fcnt_q <= '0;
      end else begin
         if (rx_push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rx_pop) begin
            rp_q <= rp_q + 1'b1;
         end
         fcnt_q <= fcnt_q + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
      end
   end

   // storage has no reset; only words counted by fcnt_q are ever read
   always_ff @(posedge pclk) begin
      if (rx_push) begin
         fifo_q[wp_q] <= rx_word;
      end
   end

   // overrun latches until receive enable or port enable is cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_error_flag_q <= 1'b0;
      end else begin
         overrun_error_flag_q <= (overrun_error_flag_q | rx_ovf) & rcsta_q.continuous_receive_enable & rcsta_q.serial_port_enable;
      end
   end

   // transmit path: write fills the shift register first, then the buffer
   logic tx_wr, tx_done, txb_load;
   logic [8:0] tx_word;
   logic [3:0] tx_last;
   assign tx_last = txsta_q.tx9 ? USS_LEN9 : USS_LEN8;
   assign tx_word = {txsta_q.tx9 & txsta_q.transmit_ninth_bit, pwdata[7:0]};
   assign tx_wr = wr & hit(paddr, USS_OFS_TXDATA) & rcsta_q.serial_port_enable;
   assign tx_done = tx_en & busy_q & smp_edge & (tx_cnt_q == tx_last);
   assign txb_load = tx_wr & ((busy_q & ~tx_done) | (tx_done & txb_v_q));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsr_q <= 9'h000;
         busy_q <= 1'b0;
         tx_cnt_q <= 4'h0;
      end else if (!rcsta_q.serial_port_enable) begin
         busy_q <= 1'b0;
         tx_cnt_q <= 4'h0;
      end else if (tx_done) begin
         // emptied shifter takes the pending byte first
         tsr_q <= txb_v_q ? txb_q : tx_word;
         busy_q <= txb_v_q | tx_wr;
         tx_cnt_q <= 4'h0;
      end else if (tx_wr && !busy_q) begin
         tsr_q <= tx_word;
         busy_q <= 1'b1;
         tx_cnt_q <= 4'h0;
      end else if (tx_en && busy_q && smp_edge) begin
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txb_q <= 9'h000;
         txb_v_q <= 1'b0;
      end else if (!rcsta_q.serial_port_enable) begin
         txb_v_q <= 1'b0;
      end else if (txb_load) begin
         txb_q <= tx_word;
         txb_v_q <= 1'b1;
      end else if (tx_done) begin
         txb_v_q <= 1'b0;
      end
   end

   // data pin: first bit appears at load, later bits on the launch edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= 1'b0;
      end else if ((tx_wr && !busy_q) || tx_done) begin
         dout_q <= (tx_done && txb_v_q) ? txb_q[0] : tx_word[0];
      end else if (tx_en && busy_q && drv_edge) begin
         dout_q <= tsr_q[tx_cnt_q];
      end
   end

   // wake and interrupt call from rising flags; the interrupt request follows the flag levels
   logic rc_evt, tx_evt, wake_evt;
   assign rc_evt = rcif & ~rcif_p_q & ie_q[USS_BIT_RCIF];
   assign tx_evt = txif & ~txif_p_q & ie_q[USS_BIT_TXIF] & core_q[USS_BIT_PERIPHERAL_IRQ_ENABLE];
   assign wake_evt = core_q[USS_BIT_SLEEP] & (rc_evt | tx_evt);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcif_p_q <= 1'b0;
         txif_p_q <= 1'b1;
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         call_q <= 1'b0;
      end else begin
         rcif_p_q <= rcif;
         txif_p_q <= txif;
         irq_q <= core_q[USS_BIT_PERIPHERAL_IRQ_ENABLE] & ((rcif & ie_q[USS_BIT_RCIF]) | (txif & ie_q[USS_BIT_TXIF]));
         wake_q <= wake_evt;
         call_q <= wake_evt & core_q[USS_BIT_GIE];
      end
   end

   // control registers; the wake event beats a same-cycle sleep write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcsta_q <= uss_rcsta_t'(USS_RST_REG);
         txsta_q <= uss_txsta_t'(USS_RST_REG);
         baud_q <= USS_RST_REG;
         ie_q <= USS_RST_REG;
         ipr_q <= USS_RST_REG;
         core_q <= USS_RST_REG;
      end else begin
         if (wr && hit(paddr, USS_OFS_RCSTA)) begin
            rcsta_q <= uss_rcsta_t'({pwdata[7:3], 3'b000});
         end
         if (wr && hit(paddr, USS_OFS_TXSTA)) begin
            txsta_q <= uss_txsta_t'({pwdata[7:2], 1'b0, pwdata[0]});
         end
         if (wr && hit(paddr, USS_OFS_BAUD)) begin
            baud_q <= pwdata[7:0] & USS_BAUD_WMASK;
         end
         if (wr && hit(paddr, USS_OFS_IRQEN)) begin
            ie_q <= pwdata[7:0];
         end
         if (wr && hit(paddr, USS_OFS_IRQPRI)) begin
            ipr_q <= pwdata[7:0];
         end
         if (wake_evt) begin
            core_q <= {core_q[7:1], 1'b0};
         end else if (wr && hit(paddr, USS_OFS_CORE)) begin
            core_q <= {pwdata[7:6], 5'b00000, pwdata[0]};
         end
      end
   end

   // read mux with live status fields
   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      unique case (1'b1)
         hit(paddr, USS_OFS_RCSTA): begin
            rd_val = {rcsta_q[7:3], 1'b0, overrun_error_flag_q, rcsta_q.rx9 & ~rx_empty & fifo_q[rp_q][8]};
         end
         hit(paddr, USS_OFS_TXSTA): rd_val = {txsta_q[7:2], ~busy_q, txsta_q.transmit_ninth_bit};
         hit(paddr, USS_OFS_BAUD): begin
            rd_val = baud_q;
            rd_val[USS_BIT_RCIDL] = ~rx_en;
         end
         hit(paddr, USS_OFS_RXDATA): rd_val = rx_empty ? 8'h00 : fifo_q[rp_q][7:0];
         hit(paddr, USS_OFS_IRQEN): rd_val = ie_q;
         hit(paddr, USS_OFS_IRQFLG): begin
            rd_val[USS_BIT_RCIF] = rcif;
            rd_val[USS_BIT_TXIF] = txif;
         end
         hit(paddr, USS_OFS_IRQPRI): rd_val = ipr_q;
         hit(paddr, USS_OFS_CORE): rd_val = core_q;
         default: rd_val = 8'h00;
      endcase
   end

   // apb slave: one wait state, answer registered in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~mapped;
         prdata_q <= (psel && penable && !pready_q && !pwrite && mapped) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign serial_data_pin_out = dout_q;
   assign serial_data_pin_oe = tx_en_q;
   assign irq_req = irq_q;
   assign wake = wake_q;
   assign isr_call = call_q;
   assign isr_addr = isr_addr_q;

   // registered pin enable and vector
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en_q <= 1'b0;
         isr_addr_q <= 12'h000;
      end else begin
         tx_en_q <= tx_en;
         isr_addr_q <= (wake_evt && core_q[USS_BIT_GIE]) ? USS_ISR_VECTOR : 12'h000;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_rx_flag_set: assert property (rx_push |=> rcif) else $error("receive flag not set");
   chk_rx_flag_clear: assert property (rx_pop && fcnt_q == 1 && !rx_push |=> !rcif)
      else $error("receive flag not cleared on empty");
   chk_overrun_set: assert property (rx_ovf && rcsta_q.continuous_receive_enable && rcsta_q.serial_port_enable |=> overrun_error_flag_q)
      else $error("overrun not latched");
   chk_overrun_clear: assert property (!rcsta_q.continuous_receive_enable |=> !overrun_error_flag_q) else $error("overrun survives receive off");
   chk_no_shift_off: assert property (!rx_en |=> rx_cnt_q == 4'h0) else $error("receiver moved while off");
   chk_tx_flag_clear: assert property (tx_wr && busy_q && !tx_done |=> !txif) else $error("transmit flag not cleared");
   chk_tx_reload: assert property (tx_done && txb_v_q && !tx_wr |=> busy_q && txif)
      else $error("buffer not moved to shifter");
   chk_wake_sleep: assert property (wake_evt |=> wake && !core_q[USS_BIT_SLEEP]) else $error("wake missing");
   chk_vector_addr: assert property (isr_call |-> isr_addr == USS_ISR_VECTOR) else $error("bad vector");
   chk_ninth_bit: assert property (rx_push && rx_empty && rcsta_q.rx9 |=> fifo_q[rp_q][8] == $past(dt_s2_q))
      else $error("ninth bit lost");

   cov_rx_word: cover property (rx_push);
   cov_overrun: cover property (rx_ovf);
   cov_tx_reload: cover property (tx_done && txb_v_q);
   cov_sleep_wake: cover property (wake_evt && core_q[USS_BIT_GIE]);
endmodule

// ==== tb/uss_master_model.sv ====
`timescale 1ns/10ps
// external clocked master: owns the shift clock and always drives its data output
module uss_master_model (
   input wire logic pclk,
   output logic sck,
   output logic sdo,
   input wire logic sdi
);
   // clock stands still low between frames
   initial begin
      sck = 1'b0;
      sdo = 1'b0;
   end
   // one frame lsb first, h pclk cycles per half period; sdi is taken just after
   // the rising edge, before the slave can have seen it
   task automatic xfer(input logic [8:0] tx, input int n, input int h, output logic [8:0] rx);
      rx = '0;
      for (int i = 0; i < n; i++) begin
         repeat (h / 2) @(posedge pclk);
         sdo <= tx[i];
         repeat (h - h / 2) @(posedge pclk);
         sck <= 1'b1;
         @(negedge pclk);
         rx[i] = sdi;
         repeat (h) @(posedge pclk);
         sck <= 1'b0;
      end
      // a released line toggles so a stale bit never looks valid
      repeat (h / 2) @(posedge pclk);
      sdo <= ~sdo;
   endtask
endmodule

// ==== tb/test_usart_sync_slave_sleep.sv ====
`timescale 1ns/10ps
// bench: apb register traffic plus an external clocked master on the pins
module test_usart_sync_slave_sleep
   import uss_pkg::*;
;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] m;
      logic [7:0] e;
      logic err;
   } uss_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic sck, m_dat, dout, doe, irq_req, wake, isr_call, pin_w;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] isr_addr, call_addr;
   logic [8:0] rx;
   int failures, checked, wakes, calls, cycles;
   uss_row_t rows [11] = '{
      '{1'b0, USS_OFS_RCSTA, 8'h00, 8'hFF, 8'h00, 1'b0},
      '{1'b0, USS_OFS_TXSTA, 8'h00, 8'hFD, 8'h00, 1'b0},
      '{1'b0, USS_OFS_BAUD, 8'h00, 8'hFF, 8'h40, 1'b0},
      '{1'b0, USS_OFS_IRQEN, 8'h00, 8'hFF, 8'h00, 1'b0},
      '{1'b0, USS_OFS_IRQFLG, 8'h00, 8'h20, 8'h00, 1'b0},
      '{1'b0, USS_OFS_CORE, 8'h00, 8'hFF, 8'h00, 1'b0},
      '{1'b1, USS_OFS_IRQPRI, 8'hA5, 8'hFF, 8'hA5, 1'b0},
      '{1'b1, USS_OFS_BAUD, 8'hFF, 8'hFF, 8'h5B, 1'b0},
      '{1'b1, USS_OFS_BAUD, 8'h00, 8'hFF, 8'h40, 1'b0},
      '{1'b1, 8'h02, 8'hFF, 8'hFF, 8'h00, 1'b1},
      '{1'b0, 8'h24, 8'h00, 8'hFF, 8'h00, 1'b1}};
   // data wire: the slave wins while its enable is up
   assign pin_w = doe ? dout : m_dat;
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   uss_top uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shift_clock_pin(sck), .serial_data_pin_in(pin_w), .serial_data_pin_out(dout),
      .serial_data_pin_oe(doe), .irq_req(irq_req), .wake(wake), .isr_call(isr_call),
      .isr_addr(isr_addr)
   );
   uss_master_model m (.pclk(pclk), .sck(sck), .sdo(m_dat), .sdi(pin_w));
   // one-cycle pulses are counted here; the cycle ceiling cuts a hang short
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
      if (isr_call === 1'b1) begin
         calls <= calls + 1;
         call_addr <= isr_addr;
      end
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // apb transfer: request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, '0);
      check(nm, rd & m, e);
   endtask
   task automatic wait_wake(input int n);
      int k;
      k = 0;
      while (wakes < n && k < 40) begin
         @(negedge pclk);
         k++;
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished, %0d checks so far", s, checked);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {failures, checked, wakes, calls, cycles} = '0;
      repeat (8) @(posedge pclk);
      check("pready in reset", 32'(pready), 32'h0000_0000);
      presetn <= 1'b1;
      // register table: reset values, access kinds, refused offsets
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, 32'(rows[i].d));
         if (rows[i].wr) apb(1'b0, rows[i].a, '0);
         check($sformatf("row %0d", i), rd & 32'(rows[i].m), 32'(rows[i].e));
         check($sformatf("row %0d err", i), 32'(er), 32'(rows[i].err));
      end
      done("registers");
      // slave receive, fifo and overrun
      wr(USS_OFS_TXSTA, 8'h10);
      wr(USS_OFS_IRQEN, 8'h20);
      wr(USS_OFS_CORE, 8'h40);
      wr(USS_OFS_RCSTA, 8'h80);
      m.xfer(9'h0A5, 8, 4, rx);
      rchk("flag while off", USS_OFS_IRQFLG, 32'h20, 32'h00);
      wr(USS_OFS_RCSTA, 8'h90);
      rchk("never idle", USS_OFS_BAUD, 32'h40, 32'h00);
      m.xfer(9'h0A5, 8, 4, rx);
      rchk("rx flag", USS_OFS_IRQFLG, 32'h20, 32'h20);
      check("irq", 32'(irq_req), 32'h0000_0001);
      m.xfer(9'h03C, 8, 4, rx);
      m.xfer(9'h00F, 8, 4, rx);
      rchk("overrun", USS_OFS_RCSTA, 32'h02, 32'h02);
      rchk("word 1", USS_OFS_RXDATA, 32'hFF, 32'hA5);
      rchk("word 2", USS_OFS_RXDATA, 32'hFF, 32'h3C);
      rchk("flag empty", USS_OFS_IRQFLG, 32'h20, 32'h00);
      rchk("overrun held", USS_OFS_RCSTA, 32'h02, 32'h02);
      wr(USS_OFS_RCSTA, 8'h80);
      rchk("overrun clear", USS_OFS_RCSTA, 32'h02, 32'h00);
      wr(USS_OFS_RCSTA, 8'hF0);
      m.xfer(9'h15A, 9, 4, rx);
      rchk("ninth bit", USS_OFS_RCSTA, 32'h01, 32'h01);
      rchk("nine low", USS_OFS_RXDATA, 32'hFF, 32'h5A);
      wr(USS_OFS_BAUD, 8'h10);
      wr(USS_OFS_RCSTA, 8'h90);
      m.xfer(9'h096, 8, 4, rx);
      rchk("falling edge", USS_OFS_RXDATA, 32'hFF, 32'h96);
      wr(USS_OFS_BAUD, 8'h00);
      done("receive");
      // receive in sleep, with and without the global enable
      wr(USS_OFS_CORE, 8'hC1);
      m.xfer(9'h0C7, 8, 4, rx);
      wait_wake(1);
      check("wake", 32'(wakes), 32'h0000_0001);
      check("isr", 32'(calls), 32'h0000_0001);
      check("vector", 32'(call_addr), 32'h0000_0004);
      rchk("sleep cleared", USS_OFS_CORE, 32'h01, 32'h00);
      rchk("sleep word", USS_OFS_RXDATA, 32'hFF, 32'hC7);
      wr(USS_OFS_CORE, 8'h41);
      m.xfer(9'h011, 8, 4, rx);
      wait_wake(2);
      check("no isr", 32'(calls), 32'h0000_0001);
      rchk("sleep word 2", USS_OFS_RXDATA, 32'hFF, 32'h11);
      wr(USS_OFS_TXSTA, 8'h90);
      wr(USS_OFS_CORE, 8'h41);
      m.xfer(9'h0E1, 8, 4, rx);
      wait_wake(3);
      check("master sleeps", 32'(wakes), 32'h0000_0002);
      rchk("no shift", USS_OFS_IRQFLG, 32'h20, 32'h00);
      done("sleep receive");
      // transmit in sleep: shift register, buffer, flag
      wr(USS_OFS_CORE, 8'h40);
      wr(USS_OFS_RCSTA, 8'h80);
      wr(USS_OFS_TXSTA, 8'h30);
      wr(USS_OFS_IRQEN, 8'h10);
      repeat (2) @(negedge pclk);
      check("drive on", 32'(doe), 32'h0000_0001);
      wr(USS_OFS_TXDATA, 8'hC3);
      wr(USS_OFS_TXDATA, 8'h5A);
      rchk("tx flag low", USS_OFS_IRQFLG, 32'h10, 32'h00);
      wr(USS_OFS_CORE, 8'h41);
      m.xfer(9'h000, 8, 4, rx);
      check("tx word 1", 32'(rx), 32'h0000_00C3);
      wait_wake(3);
      check("tx wake", 32'(wakes), 32'h0000_0003);
      rchk("tx flag", USS_OFS_IRQFLG, 32'h10, 32'h10);
      m.xfer(9'h000, 8, 4, rx);
      check("tx word 2", 32'(rx), 32'h0000_005A);
      wr(USS_OFS_TXSTA, 8'h71);
      wr(USS_OFS_TXDATA, 8'h0F);
      m.xfer(9'h000, 9, 4, rx);
      check("tx nine", 32'(rx), 32'h0000_010F);
      done("transmit");
      // second reset in mid run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("reset rx ctl", USS_OFS_RCSTA, 32'hFF, 32'h00);
      rchk("reset tx ctl", USS_OFS_TXSTA, 32'hFD, 32'h00);
      done("reset");
      summarize();
   end
endmodule
